// File: verilog/erp_pkg.sv
// Shared constants for the embedded RAM with packing, address hold and ECC
`default_nettype none
package erp_pkg;
    // ****************************************
    // Array geometry
    // ****************************************
    localparam int AW = 9;
    localparam int DEPTH = 512;
    localparam int DW = 32;
    localparam int HW = 16;
    localparam int HCW = 22;
    localparam int CW = 44;
    localparam int PAD_W = CW - DW;
    localparam logic PORT_A_HALF = 1'b0;
    localparam logic PORT_B_HALF = 1'b1;
    // ****************************************
    // Register map
    // ****************************************
    localparam int BAW = 4;
    localparam logic [BAW-1:0] OFF_CTRL = 4'h0;
    localparam logic [BAW-1:0] OFF_STAT = 4'h4;
    localparam logic [BAW-1:0] OFF_MASK = 4'h8;
    localparam int CTRL_W = 3;
    localparam int CTRL_PACK = 0;
    localparam int CTRL_ECC = 1;
    localparam int CTRL_PIPE = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam int EV_W = 2;
    localparam int EV_COR = 0;
    localparam int EV_UNC = 1;
    localparam logic [EV_W-1:0] EV_RST = 2'h0;
    // ****************************************
    // Status codes on the read port
    // ****************************************
    localparam int ST_ERR = 1;
    localparam int ST_UNC = 0;
    localparam logic [1:0] ST_NONE = 2'h0;
    localparam logic [1:0] ST_ILLEGAL = 2'h1;
    localparam logic [1:0] ST_FIXED = 2'h2;
    localparam logic [1:0] ST_BAD = 2'h3;
endpackage : erp_pkg
`default_nettype wire

// File: verilog/erp_ecc_codec.sv
// Interleaved SECDED encoder and decoder for one 32-bit word
`default_nettype none
module erp_ecc_codec (
    input wire logic [erp_pkg::DW-1:0] i_wdata,
    output logic [erp_pkg::CW-1:0] o_code,
    input wire logic [erp_pkg::CW-1:0] i_code,
    output logic [erp_pkg::DW-1:0] o_rdata,
    output logic o_err,
    output logic o_unc
);
    // ****************************************
    // Half-word Hamming code with overall parity
    // ****************************************
    function automatic logic [erp_pkg::HCW-1:0] enc16(input logic [erp_pkg::HW-1:0] d);
        logic [erp_pkg::HCW-1:0] c;
        int k;
        logic par;
        c = '0;
        k = 0;
        for (int p = 1; p < erp_pkg::HCW; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[k];
                k++;
            end
        end
        for (int j = 0; j < 5; j++) begin
            par = 1'b0;
            for (int p = 1; p < erp_pkg::HCW; p++) begin
                if (((p >> j) & 1) == 1) begin
                    par = par ^ c[p];
                end
            end
            c[1 << j] = par;
        end
        c[0] = ^c[erp_pkg::HCW-1:1];
        return c;
    endfunction : enc16

    // Returns {error, uncorrectable, data}
    function automatic logic [erp_pkg::HW+1:0] dec22(input logic [erp_pkg::HCW-1:0] cin);
        logic [erp_pkg::HCW-1:0] c;
        logic [4:0] syn;
        logic par;
        logic err;
        logic unc;
        logic [erp_pkg::HW-1:0] d;
        int k;
        c = cin;
        syn = 5'h0;
        err = 1'b0;
        unc = 1'b0;
        d = '0;
        k = 0;
        for (int p = 1; p < erp_pkg::HCW; p++) begin
            if (c[p]) begin
                syn = syn ^ 5'(p);
            end
        end
        par = ^c;
        if (par) begin
            err = 1'b1;
            if (int'(syn) >= erp_pkg::HCW) begin
                unc = 1'b1;
            end else if (syn != 5'h0) begin
                c[syn] = ~c[syn];
            end
        end else if (syn != 5'h0) begin
            err = 1'b1;
            unc = 1'b1;
        end
        for (int p = 1; p < erp_pkg::HCW; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[k] = unc ? cin[p] : c[p];
                k++;
            end
        end
        return {err, unc, d};
    endfunction : dec22

    logic [erp_pkg::HCW-1:0] enc_lo;
    logic [erp_pkg::HCW-1:0] enc_hi;
    logic [erp_pkg::HCW-1:0] got_lo;
    logic [erp_pkg::HCW-1:0] got_hi;
    logic [erp_pkg::HW+1:0] res_lo;
    logic [erp_pkg::HW+1:0] res_hi;

    // Even stored bits carry the low half, odd bits the high half
    always_comb begin
        enc_lo = enc16(i_wdata[erp_pkg::HW-1:0]);
        enc_hi = enc16(i_wdata[erp_pkg::DW-1:erp_pkg::HW]);
        for (int k = 0; k < erp_pkg::HCW; k++) begin
            o_code[2*k] = enc_lo[k];
            o_code[2*k+1] = enc_hi[k];
            got_lo[k] = i_code[2*k];
            got_hi[k] = i_code[2*k+1];
        end
        res_lo = dec22(got_lo);
        res_hi = dec22(got_hi);
        o_rdata = {res_hi[erp_pkg::HW-1:0], res_lo[erp_pkg::HW-1:0]};
        o_err = res_lo[erp_pkg::HW+1] | res_hi[erp_pkg::HW+1];
        o_unc = res_lo[erp_pkg::HW] | res_hi[erp_pkg::HW];
    end
endmodule : erp_ecc_codec
`default_nettype wire

// File: verilog/erp_ram.sv
// Two-port embedded RAM with packing, address hold and 32-bit ECC
`default_nettype none
module erp_ram (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [erp_pkg::BAW-1:0] i_bus_addr,
    input wire logic [erp_pkg::DW-1:0] i_bus_wdata,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    output logic [erp_pkg::DW-1:0] o_bus_rdata,
    output logic o_irq,
    input wire logic [erp_pkg::AW-1:0] i_a_addr,
    input wire logic [erp_pkg::DW-1:0] i_a_wdata,
    input wire logic i_a_wr,
    input wire logic i_a_rd,
    input wire logic i_a_hold,
    output logic [erp_pkg::DW-1:0] o_a_rdata,
    output logic o_a_rvalid,
    input wire logic [erp_pkg::AW-1:0] i_b_addr,
    input wire logic [erp_pkg::DW-1:0] i_b_wdata,
    input wire logic i_b_wr,
    input wire logic i_b_rd,
    input wire logic i_b_hold,
    output logic [erp_pkg::DW-1:0] o_b_rdata,
    output logic o_b_rvalid,
    output logic [1:0] o_b_status
);
    // ****************************************
    // Address mapping
    // ****************************************
    function automatic logic [erp_pkg::AW-1:0] phys(input logic half, input logic pack,
                                                    input logic [erp_pkg::AW-1:0] a);
        return pack ? {half, a[erp_pkg::AW-2:0]} : a;
    endfunction : phys

    logic [erp_pkg::CTRL_W-1:0] ctrl;
    logic [erp_pkg::EV_W-1:0] stat;
    logic [erp_pkg::EV_W-1:0] mask;
    logic ecc_on;
    logic pack_on;
    logic [erp_pkg::AW-1:0] a_addr;
    logic [erp_pkg::AW-1:0] b_addr;
    logic [erp_pkg::AW-1:0] next_a_addr;
    logic [erp_pkg::AW-1:0] next_b_addr;
    logic [erp_pkg::DW-1:0] a_wd0;
    logic [erp_pkg::DW-1:0] b_wd0;
    logic a_wr0;
    logic a_rd0;
    logic b_wr0;
    logic b_rd0;
    logic ecc0;
    logic pipe0;
    logic [erp_pkg::CW-1:0] mem [erp_pkg::DEPTH];
    logic [erp_pkg::CW-1:0] a_raw;
    logic [erp_pkg::CW-1:0] b_raw;
    logic [erp_pkg::CW-1:0] b_raw2;
    logic a_rv1;
    logic b_rv1;
    logic ecc1;
    logic pipe1;
    logic b_rv2;
    logic [erp_pkg::CW-1:0] enc_word;
    logic [erp_pkg::CW-1:0] dec_in;
    logic [erp_pkg::DW-1:0] dec_data;
    logic dec_err;
    logic dec_unc;
    logic dec_src;
    logic out_v;
    logic [erp_pkg::EV_W-1:0] ev;

    assign ecc_on = ctrl[erp_pkg::CTRL_ECC];
    // ECC mode has its own port roles, so packing only applies without it
    assign pack_on = ctrl[erp_pkg::CTRL_PACK] && !ecc_on;

    // ****************************************
    // Address registers with hold
    // ****************************************
    always_comb begin
        next_a_addr = phys(erp_pkg::PORT_A_HALF, pack_on, i_a_addr);
        next_b_addr = phys(erp_pkg::PORT_B_HALF, pack_on, i_b_addr);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            a_addr <= '0;
        end else if (!i_a_hold) begin
            a_addr <= next_a_addr;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            b_addr <= '0;
        end else if (!i_b_hold) begin
            b_addr <= next_b_addr;
        end
    end

    // ****************************************
    // Input stage
    // ****************************************
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            a_wd0 <= '0;
            b_wd0 <= '0;
            a_wr0 <= 1'b0;
            a_rd0 <= 1'b0;
            b_wr0 <= 1'b0;
            b_rd0 <= 1'b0;
            ecc0 <= 1'b0;
            pipe0 <= 1'b0;
        end else begin
            a_wd0 <= i_a_wdata;
            b_wd0 <= i_b_wdata;
            // ECC: port A only writes, port B only reads
            a_wr0 <= i_a_wr;
            a_rd0 <= i_a_rd && !ecc_on;
            b_wr0 <= i_b_wr && !ecc_on;
            b_rd0 <= i_b_rd;
            ecc0 <= ecc_on;
            pipe0 <= ctrl[erp_pkg::CTRL_PIPE];
        end
    end

    erp_ecc_codec u_codec (
        .i_wdata(a_wd0),
        .o_code(enc_word),
        .i_code(dec_in),
        .o_rdata(dec_data),
        .o_err(dec_err),
        .o_unc(dec_unc)
    );

    // ****************************************
    // Array access
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (a_wr0) begin
            // Full word always written (encoded only in ECC mode, else zero-padded), no byte masking
            mem[a_addr] <= ecc0 ? enc_word : {erp_pkg::PAD_W'(0), a_wd0};
        end
        if (b_wr0) begin
            mem[b_addr] <= {erp_pkg::PAD_W'(0), b_wd0};
        end
        a_raw <= mem[a_addr];
        if (ecc0 && a_wr0 && a_addr == b_addr) begin
            b_raw <= enc_word;
        end else begin
            b_raw <= mem[b_addr];
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            a_rv1 <= 1'b0;
            b_rv1 <= 1'b0;
            ecc1 <= 1'b0;
            pipe1 <= 1'b0;
            b_rv2 <= 1'b0;
            b_raw2 <= '0;
        end else begin
            a_rv1 <= a_rd0;
            b_rv1 <= b_rd0;
            ecc1 <= ecc0;
            pipe1 <= pipe0;
            b_rv2 <= b_rv1 && ecc1 && pipe1;
            b_raw2 <= b_raw;
        end
    end

    // ****************************************
    // Output stage
    // ****************************************
    always_comb begin
        dec_in = b_rv2 ? b_raw2 : b_raw;
        dec_src = b_rv2 || ecc1;
        out_v = b_rv2 || (b_rv1 && !(ecc1 && pipe1));
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_a_rdata <= '0;
            o_a_rvalid <= 1'b0;
        end else begin
            o_a_rdata <= a_rv1 ? a_raw[erp_pkg::DW-1:0] : '0;
            o_a_rvalid <= a_rv1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_b_rdata <= '0;
            o_b_rvalid <= 1'b0;
            o_b_status <= erp_pkg::ST_NONE;
        end else begin
            o_b_rvalid <= out_v;
            if (!out_v) begin
                o_b_rdata <= '0;
                o_b_status <= erp_pkg::ST_NONE;
            end else if (dec_src) begin
                // Codec keeps raw data when uncorrectable; array is never rewritten
                o_b_rdata <= dec_data;
                o_b_status <= {dec_err, dec_unc};
            end else begin
                o_b_rdata <= dec_in[erp_pkg::DW-1:0];
                o_b_status <= erp_pkg::ST_NONE;
            end
        end
    end

    // ****************************************
    // Register bus and interrupt
    // ****************************************
    always_comb begin
        ev = '0;
        ev[erp_pkg::EV_COR] = out_v && dec_src && dec_err && !dec_unc;
        ev[erp_pkg::EV_UNC] = out_v && dec_src && dec_unc;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl <= erp_pkg::CTRL_RST;
            mask <= erp_pkg::EV_RST;
        end else if (i_bus_wr) begin
            if (i_bus_addr == erp_pkg::OFF_CTRL) begin
                ctrl <= i_bus_wdata[erp_pkg::CTRL_W-1:0];
            end
            if (i_bus_addr == erp_pkg::OFF_MASK) begin
                mask <= i_bus_wdata[erp_pkg::EV_W-1:0];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stat <= erp_pkg::EV_RST;
        end else if (i_bus_wr && i_bus_addr == erp_pkg::OFF_STAT) begin
            stat <= (stat & ~i_bus_wdata[erp_pkg::EV_W-1:0]) | ev;
        end else begin
            stat <= stat | ev;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_bus_rdata <= '0;
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(stat & mask);
            o_bus_rdata <= '0;
            if (i_bus_rd) begin
                unique case (i_bus_addr)
                    erp_pkg::OFF_CTRL: o_bus_rdata <= erp_pkg::DW'(ctrl);
                    erp_pkg::OFF_STAT: o_bus_rdata <= erp_pkg::DW'(stat);
                    erp_pkg::OFF_MASK: o_bus_rdata <= erp_pkg::DW'(mask);
                    default: o_bus_rdata <= '0;
                endcase
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence b_ecc_read_s;
        b_rd0 && ecc0;
    endsequence

    sequence b_ecc_read_piped_s;
        b_ecc_read_s ##0 pipe0;
    endsequence

    status_legal_a: assert property (o_b_status != erp_pkg::ST_ILLEGAL)
        else $error("illegal status code on read port");
    hold_keeps_a: assert property (i_a_hold |=> $stable(a_addr))
        else $error("port A address moved while held");
    hold_indep_a: assert property (i_a_hold && !i_b_hold |=> b_addr == $past(next_b_addr))
        else $error("port B address did not load while port A held");
    addr_load_a: assert property (!i_a_hold |=> a_addr == $past(next_a_addr))
        else $error("port A address did not load");
    pipe_lat_a: assert property (b_ecc_read_piped_s |-> ##3 o_b_rvalid)
        else $error("pipelined ECC read not three cycles");
    nopipe_lat_a: assert property (b_ecc_read_s ##0 !pipe0 |-> ##2 o_b_rvalid)
        else $error("ECC read without pipeline not two cycles");
    status_valid_a: assert property (o_b_status != erp_pkg::ST_NONE |-> o_b_rvalid)
        else $error("status flags without read data");
    packed_half_a: assert property (pack_on && !i_a_hold && !i_b_hold |=>
        a_addr[erp_pkg::AW-1] == erp_pkg::PORT_A_HALF &&
        b_addr[erp_pkg::AW-1] == erp_pkg::PORT_B_HALF)
        else $error("packed port addressed wrong half");
    ecc_sdp_a: assert property (ecc0 |-> !b_wr0 && !a_rd0)
        else $error("ECC mode not simple dual-port");
    irq_level_a: assert property ((|(stat & mask)) |=> o_irq)
        else $error("interrupt not raised");
endmodule : erp_ram
`default_nettype wire

// File: verif/erp_fabric.sv
// User fabric model that drives both RAM ports
`default_nettype none
module erp_fabric (
    input wire logic i_clk,
    output logic [erp_pkg::AW-1:0] o_a_addr,
    output logic [erp_pkg::DW-1:0] o_a_wdata,
    output logic o_a_wr,
    output logic o_a_rd,
    output logic o_a_hold,
    output logic [erp_pkg::AW-1:0] o_b_addr,
    output logic [erp_pkg::DW-1:0] o_b_wdata,
    output logic o_b_wr,
    output logic o_b_rd,
    output logic o_b_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_a_addr, o_a_wdata, o_a_wr, o_a_rd, o_a_hold} = '0;
        {o_b_addr, o_b_wdata, o_b_wr, o_b_rd, o_b_hold} = '0;
    end
    // ****************************************
    // Requests
    // ****************************************
    // One cycle on port A (p 0), port B (p 1) or both (p 2); whole words only
    // Packed callers keep within one half; no reliance on 4+ bit detection
    task automatic issue(input int p, input logic [8:0] a, input logic [31:0] d,
                         input bit wr, input bit rd, input bit hold);
        @(posedge i_clk);
        o_a_wr <= (p != 1) & wr;
        o_a_rd <= (p != 1) & rd;
        o_b_wr <= (p != 0) & wr;
        o_b_rd <= (p != 0) & rd;
        if (p != 1) begin
            o_a_addr <= a;
            o_a_wdata <= d;
            o_a_hold <= hold;
        end
        if (p != 0) begin
            o_b_addr <= a;
            o_b_wdata <= d;
            o_b_hold <= hold;
        end
    endtask : issue
    // Drop strobes; write data no longer qualified, so scramble it
    task automatic idle();
        o_a_wr <= 1'b0;
        o_a_rd <= 1'b0;
        o_b_wr <= 1'b0;
        o_b_rd <= 1'b0;
        o_a_wdata <= ~o_a_wdata;
        o_b_wdata <= ~o_b_wdata;
    endtask : idle
endmodule : erp_fabric
`default_nettype wire

// File: verif/tb_erp_ram.sv
// Self-checking bench for the embedded RAM block
`default_nettype none
module tb_erp_ram;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_sys_rst, bus_wr, bus_rd, irq;
    logic [3:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata, a_wdata, b_wdata, a_rdata, b_rdata;
    logic [8:0] a_addr, b_addr;
    logic a_wr, a_rd, a_hold, b_wr, b_rd, b_hold, a_rvalid, b_rvalid;
    logic [1:0] b_status;
    int miscompares = 0;
    int n_tests = 0;
    erp_ram i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus_addr(bus_addr),
        .i_bus_wdata(bus_wdata), .i_bus_wr(bus_wr), .i_bus_rd(bus_rd),
        .o_bus_rdata(bus_rdata), .o_irq(irq), .i_a_addr(a_addr), .i_a_wdata(a_wdata),
        .i_a_wr(a_wr), .i_a_rd(a_rd), .i_a_hold(a_hold), .o_a_rdata(a_rdata),
        .o_a_rvalid(a_rvalid), .i_b_addr(b_addr), .i_b_wdata(b_wdata), .i_b_wr(b_wr),
        .i_b_rd(b_rd), .i_b_hold(b_hold), .o_b_rdata(b_rdata), .o_b_rvalid(b_rvalid),
        .o_b_status(b_status));
    erp_fabric i_fab (.i_clk(i_clk), .o_a_addr(a_addr), .o_a_wdata(a_wdata),
        .o_a_wr(a_wr), .o_a_rd(a_rd), .o_a_hold(a_hold), .o_b_addr(b_addr),
        .o_b_wdata(b_wdata), .o_b_wr(b_wr), .o_b_rd(b_rd), .o_b_hold(b_hold));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge i_clk);
        bus_wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge i_clk);
        bus_rd <= 1'b0;
        @(negedge i_clk);
        d = bus_rdata;
    endtask : reg_rd
    task automatic ram_wr(input int p, input logic [8:0] a, input logic [31:0] d,
                          input bit hold);
        i_fab.issue(p, a, d, 1'b1, 1'b0, hold);
        @(posedge i_clk);
        i_fab.idle();
    endtask : ram_wr
    // Read (with optional write); lat counts cycles from the edge that takes it
    task automatic ram_rd(input int p, input logic [8:0] a, input bit hold, input bit wr,
                          input logic [31:0] wd, output logic [31:0] d,
                          output logic [1:0] st, output int lat);
        i_fab.issue(p, a, wd, wr, 1'b1, hold);
        @(posedge i_clk);
        i_fab.idle();
        for (lat = 0; lat < 6; lat++) begin
            @(negedge i_clk);
            if ((p == 0) ? a_rvalid : b_rvalid) break;
            @(posedge i_clk);
        end
        d = (p == 0) ? a_rdata : b_rdata;
        st = b_status;
    endtask : ram_rd
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        logic [31:0] d;
        reg_rd(erp_pkg::OFF_CTRL, d); chk("ctrl reset", 32'h0, d);
        reg_rd(erp_pkg::OFF_STAT, d); chk("stat reset", 32'h0, d);
        reg_rd(erp_pkg::OFF_MASK, d); chk("mask reset", 32'h0, d);
        reg_wr(4'hc, 32'hffffffff);
        reg_rd(4'hc, d); chk("unmapped", 32'h0, d);
        reg_wr(erp_pkg::OFF_CTRL, 32'h7);
        reg_rd(erp_pkg::OFF_CTRL, d); chk("ctrl rw", 32'h7, d);
        reg_wr(erp_pkg::OFF_MASK, 32'h3);
        reg_rd(erp_pkg::OFF_MASK, d); chk("mask rw", 32'h3, d);
        reg_wr(erp_pkg::OFF_MASK, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_packed();
        logic [31:0] d;
        logic [1:0] s;
        int n;
        reg_wr(erp_pkg::OFF_CTRL, 32'h1);
        ram_wr(0, 9'h005, 32'h1111aaaa, 1'b0);
        ram_wr(1, 9'h005, 32'h2222bbbb, 1'b0);
        ram_rd(0, 9'h005, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("packed a", 32'h1111aaaa, d);
        chk("read lat", 32'h2, 32'(n));
        ram_rd(1, 9'h005, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("packed b", 32'h2222bbbb, d);
        reg_wr(erp_pkg::OFF_CTRL, 32'h0);
        ram_rd(0, 9'h105, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("upper half", 32'h2222bbbb, d);
        ram_rd(0, 9'h005, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("lower half", 32'h1111aaaa, d);
        $display("test packed done");
    endtask : t_packed
    task automatic t_hold();
        logic [31:0] d;
        logic [1:0] s;
        int n;
        ram_wr(0, 9'h014, 32'h0000cccc, 1'b0);
        ram_wr(0, 9'h00a, 32'h0, 1'b0);
        ram_wr(0, 9'h014, 32'h0000dddd, 1'b1);
        ram_rd(0, 9'h014, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("held write skip", 32'h0000cccc, d);
        ram_rd(0, 9'h00a, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("held write", 32'h0000dddd, d);
        i_fab.issue(0, 9'h014, 32'h0, 1'b0, 1'b0, 1'b0);
        i_fab.issue(0, 9'h00a, 32'h0, 1'b0, 1'b0, 1'b1);
        ram_rd(1, 9'h00a, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("other port", 32'h0000dddd, d);
        ram_rd(0, 9'h00a, 1'b1, 1'b0, 32'h0, d, s, n);
        chk("held read", 32'h0000cccc, d);
        i_fab.issue(0, 9'h000, 32'h0, 1'b0, 1'b0, 1'b0);
        $display("test hold done");
    endtask : t_hold
    task automatic t_ecc();
        logic [31:0] d;
        logic [1:0] s;
        int n;
        reg_wr(erp_pkg::OFF_CTRL, 32'h2);
        ram_wr(0, 9'h007, 32'h5a5a0ff0, 1'b0);
        ram_rd(1, 9'h007, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("ecc data", 32'h5a5a0ff0, d);
        chk("ecc status", 32'h0, 32'(s));
        chk("ecc lat", 32'h2, 32'(n));
        ram_rd(0, 9'h007, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("a read refused", 32'h6, 32'(n));
        ram_wr(1, 9'h007, 32'hffffffff, 1'b0);
        ram_rd(1, 9'h007, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("b write refused", 32'h5a5a0ff0, d);
        ram_rd(2, 9'h007, 1'b0, 1'b1, 32'h12345678, d, s, n);
        chk("new data", 32'h12345678, d);
        reg_wr(erp_pkg::OFF_CTRL, 32'h6);
        ram_rd(1, 9'h007, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("pipe data", 32'h12345678, d);
        chk("pipe lat", 32'h3, 32'(n));
        $display("test ecc done");
    endtask : t_ecc
    // Stores a raw pattern over an encoded zero word, then reads it back decoded
    task automatic corrupt_rd(input logic [31:0] raw, output logic [31:0] d,
                              output logic [1:0] s);
        int n;
        reg_wr(erp_pkg::OFF_CTRL, 32'h0);
        ram_wr(0, 9'h009, raw, 1'b0);
        reg_wr(erp_pkg::OFF_CTRL, 32'h2);
        ram_rd(1, 9'h009, 1'b0, 1'b0, 32'h0, d, s, n);
    endtask : corrupt_rd
    task automatic t_err();
        logic [31:0] d;
        logic [1:0] s;
        int n;
        reg_wr(erp_pkg::OFF_CTRL, 32'h2);
        ram_wr(0, 9'h009, 32'h0, 1'b0);
        reg_wr(erp_pkg::OFF_MASK, 32'h3);
        corrupt_rd(32'h1, d, s);
        chk("single data", 32'h0, d);
        chk("single status", 32'(erp_pkg::ST_FIXED), 32'(s));
        ram_rd(1, 9'h009, 1'b0, 1'b0, 32'h0, d, s, n);
        chk("no write-back", 32'(erp_pkg::ST_FIXED), 32'(s));
        reg_rd(erp_pkg::OFF_STAT, d);
        chk("cor event", 32'h1, d);
        chk("irq on", 32'h1, 32'(irq));
        reg_wr(erp_pkg::OFF_STAT, 32'h3);
        corrupt_rd(32'h3, d, s);
        chk("adjacent data", 32'h0, d);
        chk("adjacent status", 32'(erp_pkg::ST_FIXED), 32'(s));
        corrupt_rd(32'h7, d, s);
        chk("triple status", 32'(erp_pkg::ST_BAD), 32'(s));
        reg_rd(erp_pkg::OFF_STAT, d);
        chk("event", 32'h3, d);
        reg_wr(erp_pkg::OFF_MASK, 32'h0);
        reg_rd(erp_pkg::OFF_MASK, d);
        chk("irq masked", 32'h0, 32'(irq));
        reg_wr(erp_pkg::OFF_STAT, 32'h3);
        reg_rd(erp_pkg::OFF_STAT, d);
        chk("stat clear", 32'h0, d);
        $display("test err done");
    endtask : t_err
    // ****************************************
    // Run
    // ****************************************
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        #(40 * 20000);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        i_sys_rst = 1'b1;
        {bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_regs();
        t_packed();
        t_hold();
        t_ecc();
        t_err();
        tally_and_finish();
    end
endmodule : tb_erp_ram
`default_nettype wire
